// [include/scbr_pkg.sv]
// Constants, types and helpers of the sensor configuration and bus relay
package scbr_pkg;
	// ------------------------------------------------------------------
	// Virtual sensors and the physical sensors behind them
	// ------------------------------------------------------------------
	localparam int         NUM_SNS   = 7;
	localparam int         NUM_GRP   = 3;
	// Order: accel, gravity, linear accel, gyro, gyro uncal, mag, mag uncal
	localparam logic [NUM_SNS-1:0][1:0] SNS_GRP =
		{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
	// Default ranges: g for accel, deg/s for gyro, uT for magnetometer
	localparam logic [NUM_GRP-1:0][15:0] GRP_DEF_RANGE =
		{16'h0514, 16'h07D0, 16'h0004};
	// ------------------------------------------------------------------
	// Register map (byte-wide fields sit in the low bits of a 16-bit word)
	// ------------------------------------------------------------------
	localparam logic [7:0] CFG_LAST  = 8'h1B;
	localparam logic [1:0] F_RATE    = 2'h0;
	localparam logic [1:0] F_LAT     = 2'h1;
	localparam logic [1:0] F_SENS    = 2'h2;
	localparam logic [3:0] PT_PAGE   = 4'hF;
	localparam logic [7:0] PT_BASE   = 8'h20;
	localparam logic [7:0] PT_CMD    = 8'h28;
	localparam logic [2:0] PT_B_ADDR = 3'h0;
	localparam logic [2:0] PT_B_REG  = 3'h1;
	localparam logic [2:0] PT_B_LEN  = 3'h2;
	localparam logic [2:0] PT_B_STAT = 3'h3;
	localparam logic [7:0] PT_MAX    = 8'h04;
	// Completion status codes
	localparam logic [7:0] STAT_BUSY = 8'h00;
	localparam logic [7:0] STAT_OK   = 8'h01;
	localparam logic [7:0] STAT_ERR  = 8'h02;
	// Pass-through parameter numbers
	localparam logic [2:0] CMD_RD_MULTI = 3'h1;
	localparam logic [2:0] CMD_RD_SGL   = 3'h3;
	localparam logic [2:0] CMD_RD_SLOW  = 3'h5;
	localparam logic [2:0] CMD_WR_SLOW  = 3'h6;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_NS      = 10;
	localparam int QTR_NS      = 625;
	localparam int QTR_CYC     = (QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_US      = 500;
	localparam int GAP_CYC     = (GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int RATE_DLY_US = 1000;
	localparam int RATE_CYC    = (RATE_DLY_US * 1000) / CLK_NS;
	localparam int MS_US       = 1000;
	localparam int MS_CYC      = (MS_US * 1000) / CLK_NS;
	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_WBIT, ST_WACK, ST_RBIT, ST_RACK, ST_STOP, ST_GAP
	} scbr_ist_e;
	typedef enum logic [2:0] {PH_AW, PH_REG, PH_DAT, PH_RS, PH_AR} scbr_ph_e;
	typedef struct packed {
		logic [NUM_SNS-1:0] rate_chg;
		logic [NUM_GRP-1:0] range_chg;
		logic [NUM_SNS-1:0] flush;
		logic [NUM_SNS-1:0] batch_due;
	} scbr_evt_s;
	typedef struct packed {
		logic scl_o;
		logic scl_oe_n;
		logic sda_o;
		logic sda_oe_n;
	} scbr_i2c_s;
	typedef struct packed {
		logic [NUM_SNS-1:0][15:0] req_rate, act_rate, lat, sens, rng_req, lt;
		logic [NUM_SNS-1:0]       pend;
		logic [NUM_GRP-1:0][15:0] phys;
		logic [NUM_GRP-1:0][31:0] scale;
		scbr_evt_s                evt;
		logic [31:0]              rdly, mscnt, gcnt;
		logic [15:0]              rdata;
		logic [7:0]               pt_addr, pt_reg, pt_len, pt_stat, cur_reg, sh;
		logic [3:0][7:0]          pt_data;
		logic [2:0]               cmd, idx, bitn;
		logic [1:0]               qp;
		logic [7:0]               qdiv;
		logic                     err, scl_low, sda_low;
		scbr_ist_e                ist;
		scbr_ph_e                 ph;
	} scbr_state_s;

	// Next power of two at or above the request, saturating at full scale
	function automatic logic [15:0] scbr_rate_quant(input logic [15:0] r);
		logic [15:0] p;
		p = 16'h0001;
		if (r == 16'h0000) return 16'h0000;
		if (r > 16'h8000) return 16'hFFFF;
		for (int b = 0; b < 16; b++) begin
			if (p < r) p = p << 1;
		end
		return p;
	endfunction : scbr_rate_quant
endpackage : scbr_pkg

// [rtl/scbr_top.sv]
// Sensor configuration store, range resolver and I2C pass-through relay
//
// Summary of operation
// - Sample rate is 16 bits in Hz; reads return the rate in use.
// - Latency is 16-bit ms; zero is non-batch; nonzero needs nonzero rate.
// - Rate change lands after a delay, within 90%..210%, with an event.
// - Latency change acts at once on the running latency timer.
// - Latency written to zero from nonzero acts as a flush.
// - Change sensitivity is a stored 16-bit value for later use.
// - Dynamic range is 16 bits; zero asks for the default range.
// - Shared physical range is the largest request and is read back.
// - Zero range requests take no part in the largest-value choice.
// - Accel, gravity, linear share accel; gyros share; magnetometers share.
// - Scale factor follows range, data width and signedness.
// - Ranges are in g, degrees per second and microtesla.
// - Relay page: target, register, length up to 4, status, four data.
// - Writes use the same layout, data bytes carry the values.
// - Odd parameter numbers read, even parameter numbers write.
// - Parameters 1 and 2 make one multi-byte bus transfer.
// - Parameters 3 and 4 make single-byte transfers, register plus one.
// - Parameters 5 and 6 add a 0.5 ms pause between single transfers.
// - Status 0 busy or never issued, 1 success, 2 NACK or error.
// - Status byte writes are ignored; address, register, length read back.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module scbr_top import scbr_pkg::*; #(
	parameter int DATA_W   = 16,
	parameter bit SIGNED_D = 1'b1,
	parameter int QTR_C    = QTR_CYC,
	parameter int GAP_C    = GAP_CYC,
	parameter int RATE_C   = RATE_CYC,
	parameter int MS_C     = MS_CYC
) (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_sys_rst,
	input  wire logic [7:0]               i_addr,
	input  wire logic [15:0]              i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [15:0]              o_rdata,
	input  wire logic                     i_rate_evt_en,
	input  wire logic                     i_range_evt_en,
	output scbr_evt_s                     o_evt,
	output logic      [NUM_GRP-1:0][15:0] o_phys_range,
	output logic      [NUM_GRP-1:0][31:0] o_scale,
	output logic                          o_pt_busy,
	input  wire logic                     i_sda_in,
	output scbr_i2c_s                     o_i2c
);
	// ------------------------------------------------------------------
	// Elaboration checks and derived constants
	// ------------------------------------------------------------------
	localparam int MAG_BITS = DATA_W - int'(SIGNED_D);
	if (DATA_W < 2 || DATA_W > 16) $error("DATA_W must be 2 to 16");
	if (QTR_C < 1 || QTR_C > 255) $error("QTR_C must be 1 to 255");
	if (GAP_C < 1 || RATE_C < 1 || MS_C < 1) $error("counts must be >= 1");

	// Units per LSB in Q16 for a given full-scale range
	function automatic logic [31:0] scale_of(input logic [15:0] r);
		return (32'(r) << 16) >> MAG_BITS;
	endfunction : scale_of

	function automatic logic [NUM_GRP-1:0][31:0] def_scale();
		logic [NUM_GRP-1:0][31:0] s;
		for (int g = 0; g < NUM_GRP; g++) s[g] = scale_of(GRP_DEF_RANGE[g]);
		return s;
	endfunction : def_scale

	localparam logic [NUM_GRP-1:0][31:0] DEF_SCALE = def_scale();

	scbr_state_s q;
	scbr_state_s n;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [2:0]               s;
		logic [2:0]               b;
		logic [NUM_GRP-1:0][15:0] mx;
		logic                     ms_tick;
		logic                     qtick;
		logic                     single;
		logic                     last;
		s       = i_addr[4:2];
		b       = i_addr[2:0];
		mx      = '0;
		ms_tick = (q.mscnt == 32'(MS_C - 1));
		qtick   = (q.qdiv == 8'(QTR_C - 1));
		single  = (q.cmd >= CMD_RD_SGL);
		last    = single || (q.idx == 3'(q.pt_len - 8'h01));
		n       = q;
		n.evt   = '0;
		n.rdata = '0;
		n.mscnt = ms_tick ? 32'h0 : q.mscnt + 32'h1;

		// Pending rate changes land together once the delay runs out
		if (|q.pend) begin
			if (q.rdly == 32'h0) begin
				for (int i = 0; i < NUM_SNS; i++) begin
					if (q.pend[i]) begin
						n.act_rate[i]     = scbr_rate_quant(q.req_rate[i]);
						n.pend[i]         = 1'b0;
						n.evt.rate_chg[i] = i_rate_evt_en;
					end
				end
			end else begin
				n.rdly = q.rdly - 32'h1;
			end
		end

		// Latency timers compare against the latency now in force
		for (int i = 0; i < NUM_SNS; i++) begin
			if (q.lat[i] == 16'h0 || q.act_rate[i] == 16'h0) begin
				n.lt[i] = 16'h0;
			end else if (ms_tick) begin
				if (q.lt[i] + 16'h1 >= q.lat[i]) begin
					n.lt[i]            = 16'h0;
					n.evt.batch_due[i] = 1'b1;
				end else begin
					n.lt[i] = q.lt[i] + 16'h1;
				end
			end
		end

		// Largest nonzero request per physical sensor, else its default
		for (int i = 0; i < NUM_SNS; i++) begin
			if (q.rng_req[i] > mx[SNS_GRP[i]]) begin
				mx[SNS_GRP[i]] = q.rng_req[i];
			end
		end
		for (int g = 0; g < NUM_GRP; g++) begin
			if (mx[g] == 16'h0) mx[g] = GRP_DEF_RANGE[g];
			n.phys[g]          = mx[g];
			n.scale[g]         = scale_of(mx[g]);
			n.evt.range_chg[g] = (mx[g] != q.phys[g]) && i_range_evt_en;
		end

		// Configuration writes
		if (i_wr && i_addr <= CFG_LAST) begin
			case (i_addr[1:0])
				F_RATE: begin
					n.req_rate[s] = i_wdata;
					n.pend[s]     = 1'b1;
					n.rdly        = 32'(RATE_C);
					if (i_wdata == 16'h0) begin
						n.lat[s]       = 16'h0;
						n.evt.flush[s] = (q.lat[s] != 16'h0);
					end
				end
				F_LAT: begin
					if (i_wdata == 16'h0 || q.req_rate[s] != 16'h0) begin
						n.lat[s]       = i_wdata;
						n.evt.flush[s] = (i_wdata == 16'h0) && (q.lat[s] != 16'h0);
					end
				end
				F_SENS: n.sens[s] = i_wdata;
				default: n.rng_req[s] = i_wdata;
			endcase
		end

		// Relay page writes, taken only while the relay is idle
		if (i_wr && q.ist == ST_IDLE && i_addr[7:3] == PT_BASE[7:3]) begin
			case (b)
				PT_B_ADDR: n.pt_addr = i_wdata[7:0];
				PT_B_REG:  n.pt_reg  = i_wdata[7:0];
				PT_B_LEN:  n.pt_len  = i_wdata[7:0];
				PT_B_STAT: n.pt_stat = q.pt_stat;
				default:   n.pt_data[b[1:0]] = i_wdata[7:0];
			endcase
		end
		if (i_wr && q.ist == ST_IDLE && i_addr == PT_CMD &&
			i_wdata[2:0] >= CMD_RD_MULTI && i_wdata[2:0] <= CMD_WR_SLOW) begin
			n.cmd = i_wdata[2:0];
			if (q.pt_len == 8'h0 || q.pt_len > PT_MAX) begin
				n.pt_stat = STAT_ERR;
			end else begin
				n.pt_stat = STAT_BUSY;
				n.ist     = ST_START;
				n.ph      = PH_AW;
				n.idx     = 3'h0;
				n.cur_reg = q.pt_reg;
				n.qp      = 2'h0;
				n.qdiv    = 8'h0;
				n.err     = 1'b0;
			end
		end

		// Register reads, answered one cycle later
		if (i_rd) begin
			if (i_addr <= CFG_LAST) begin
				case (i_addr[1:0])
					F_RATE:  n.rdata = q.act_rate[s];
					F_LAT:   n.rdata = q.lat[s];
					F_SENS:  n.rdata = q.sens[s];
					default: n.rdata = q.phys[SNS_GRP[s]];
				endcase
			end else if (i_addr[7:3] == PT_BASE[7:3]) begin
				case (b)
					PT_B_ADDR: n.rdata = {8'h0, q.pt_addr};
					PT_B_REG:  n.rdata = {8'h0, q.pt_reg};
					PT_B_LEN:  n.rdata = {8'h0, q.pt_len};
					PT_B_STAT: n.rdata = {8'h0, q.pt_stat};
					default:   n.rdata = {8'h0, q.pt_data[b[1:0]]};
				endcase
			end else if (i_addr == PT_CMD) begin
				n.rdata = {13'h0, q.cmd};
			end
		end

		// Quarter-bit divider of the bus engine
		if (q.ist != ST_IDLE && q.ist != ST_GAP) begin
			n.qdiv = qtick ? 8'h0 : q.qdiv + 8'h1;
		end
		if (q.ist == ST_GAP) begin
			if (q.gcnt == 32'h0) n.ist = ST_START;
			else n.gcnt = q.gcnt - 32'h1;
		end

		// Bus engine, one step per quarter of a bit
		if (qtick && q.ist != ST_IDLE && q.ist != ST_GAP) begin
			n.qp = q.qp + 2'h1;
			case (q.ist)
				ST_START: begin
					if (q.qp == 2'h0) n.sda_low = 1'b0;
					else if (q.qp == 2'h1) n.scl_low = 1'b0;
					else if (q.qp == 2'h2) n.sda_low = 1'b1;
					else begin
						n.scl_low = 1'b1;
						n.bitn    = 3'h7;
						n.ist     = ST_WBIT;
						n.sh      = {q.pt_addr[6:0], q.ph == PH_RS};
						n.ph      = (q.ph == PH_RS) ? PH_AR : PH_AW;
					end
				end
				ST_WBIT: begin
					if (q.qp == 2'h0) n.sda_low = ~q.sh[7];
					else if (q.qp == 2'h1) n.scl_low = 1'b0;
					else if (q.qp == 2'h3) begin
						n.scl_low = 1'b1;
						n.sh      = {q.sh[6:0], 1'b0};
						n.bitn    = q.bitn - 3'h1;
						if (q.bitn == 3'h0) n.ist = ST_WACK;
					end
				end
				ST_WACK: begin
					if (q.qp == 2'h0) n.sda_low = 1'b0;
					else if (q.qp == 2'h1) n.scl_low = 1'b0;
					else if (q.qp == 2'h2) n.err = i_sda_in;
					else begin
						n.scl_low = 1'b1;
						n.bitn    = 3'h7;
						n.ist     = ST_WBIT;
						if (q.err) n.ist = ST_STOP;
						else begin
							case (q.ph)
								PH_AW: begin
									n.sh = q.cur_reg;
									n.ph = PH_REG;
								end
								PH_REG: begin
									if (q.cmd[0]) begin
										n.ph  = PH_RS;
										n.ist = ST_START;
									end else begin
										n.ph = PH_DAT;
										n.sh = q.pt_data[q.idx[1:0]];
									end
								end
								PH_DAT: begin
									n.idx = q.idx + 3'h1;
									n.sh  = q.pt_data[2'(q.idx + 3'h1)];
									if (last) n.ist = ST_STOP;
								end
								default: n.ist = ST_RBIT;
							endcase
						end
					end
				end
				ST_RBIT: begin
					if (q.qp == 2'h0) n.sda_low = 1'b0;
					else if (q.qp == 2'h1) n.scl_low = 1'b0;
					else if (q.qp == 2'h2) n.sh = {q.sh[6:0], i_sda_in};
					else begin
						n.scl_low = 1'b1;
						n.bitn    = q.bitn - 3'h1;
						if (q.bitn == 3'h0) n.ist = ST_RACK;
					end
				end
				ST_RACK: begin
					if (q.qp == 2'h0) n.sda_low = ~last;
					else if (q.qp == 2'h1) n.scl_low = 1'b0;
					else if (q.qp == 2'h3) begin
						n.scl_low             = 1'b1;
						n.pt_data[q.idx[1:0]] = q.sh;
						n.idx                 = q.idx + 3'h1;
						n.bitn                = 3'h7;
						n.ist                 = last ? ST_STOP : ST_RBIT;
					end
				end
				ST_STOP: begin
					if (q.qp == 2'h0) n.sda_low = 1'b1;
					else if (q.qp == 2'h1) n.scl_low = 1'b0;
					else if (q.qp == 2'h2) n.sda_low = 1'b0;
					else if (q.err) begin
						n.pt_stat = STAT_ERR;
						n.ist     = ST_IDLE;
					end else if (8'(q.idx) == q.pt_len) begin
						n.pt_stat = STAT_OK;
						n.ist     = ST_IDLE;
					end else begin
						n.cur_reg = q.cur_reg + 8'h01;
						n.ph      = PH_AW;
						n.gcnt    = 32'(GAP_C - 1);
						n.ist     = (q.cmd >= CMD_RD_SLOW) ? ST_GAP : ST_START;
					end
				end
				default: n.ist = ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			q       <= '0;
			q.phys  <= GRP_DEF_RANGE;
			q.scale <= DEF_SCALE;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from the state; the bus pins are open drain
	assign o_rdata        = q.rdata;
	assign o_evt          = q.evt;
	assign o_phys_range   = q.phys;
	assign o_scale        = q.scale;
	assign o_pt_busy      = (q.ist != ST_IDLE);
	assign o_i2c.scl_o    = 1'b0;
	assign o_i2c.sda_o    = 1'b0;
	assign o_i2c.scl_oe_n = ~q.scl_low;
	assign o_i2c.sda_oe_n = ~q.sda_low;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_flush_on_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_wr && i_addr <= CFG_LAST && i_addr[1:0] == F_LAT && i_wdata == 16'h0 &&
		 q.lat[i_addr[4:2]] != 16'h0) |=> o_evt.flush[$past(i_addr[4:2])])
		else $error("latency cleared without flush");
	chk_lat_needs_rate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(q.lat[0] != 16'h0) |-> (q.req_rate[0] != 16'h0))
		else $error("nonzero latency with zero rate");
	chk_rate_window: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(!q.pend[0] && q.req_rate[0] != 16'h0 && $past(q.pend[0])) |->
		(32'(q.act_rate[0]) * 32'd10 >= 32'(q.req_rate[0]) * 32'd9 &&
		 32'(q.act_rate[0]) * 32'd10 <= 32'(q.req_rate[0]) * 32'd21))
		else $error("selected rate outside window");
	chk_range_max: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($stable(q.rng_req) && q.rng_req[2] != 16'h0) |->
		(q.phys[0] >= q.rng_req[2] && q.phys[0] >= q.rng_req[0]))
		else $error("physical range below a request");
	chk_status_busy: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_wr && i_addr == PT_CMD && q.ist == ST_IDLE && i_wdata[2:0] != 3'h0 &&
		 i_wdata[2:0] <= CMD_WR_SLOW && q.pt_len != 8'h0 && q.pt_len <= PT_MAX)
		|=> (q.pt_stat == STAT_BUSY) ##1 (q.pt_stat == STAT_BUSY))
		else $error("new request did not show busy");
	chk_done_status: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		$fell(o_pt_busy) |-> (q.pt_stat == STAT_OK || q.pt_stat == STAT_ERR))
		else $error("finished without final status");
	chk_stat_ignored: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(i_wr && i_addr == PT_BASE + 8'(PT_B_STAT)) |=> $stable(q.pt_stat))
		else $error("status byte took a write");
	chk_reg_step: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(q.ist == ST_STOP && (n.ist == ST_START || n.ist == ST_GAP)) |=>
		(q.cur_reg == $past(q.cur_reg) + 8'h01))
		else $error("register address did not advance");
	chk_gap_len: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($past(q.ist) == ST_GAP && q.ist != ST_GAP) |-> ($past(q.gcnt) == 32'h0))
		else $error("pause cut short");
endmodule : scbr_top

// [bench/scbr_i2c_dev.sv]
// Behavioural I2C target with a register array, facing the relay
`timescale 1ns/100ps
module scbr_i2c_dev #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_nack,
	output logic      o_pull
);
	logic [7:0] sh;
	logic [7:0] ptr     = 8'h00;
	logic [7:0] mem [256];
	logic       act     = 1'b0;
	logic       first   = 1'b0;
	logic       got_reg = 1'b0;
	logic       rd      = 1'b0;
	int         bitc    = 0;
	int         n_start = 0;
	initial o_pull = 1'b0;
	// START or repeated START opens an address phase
	always @(negedge i_sda) if (i_scl) begin
		act = 1'b1;
		first = 1'b1;
		rd = 1'b0;
		bitc = 0;
		n_start++;
	end
	// STOP ends the transfer
	always @(posedge i_sda) if (i_scl) act = 1'b0;
	// Shift in on the rising clock; a refused read byte ends the read
	always @(posedge i_scl) begin
		if (act && bitc < 8) begin
			sh = {sh[6:0], i_sda};
			bitc++;
		end else if (act && bitc == 9 && rd && i_sda) begin
			act = 1'b0;
		end
	end
	// Acknowledge, store and present read bits on the falling clock
	always @(negedge i_scl) begin
		if (act && bitc == 8 && !rd) begin
			if (first) begin
				o_pull = !i_nack && sh[7:1] == DEV_ADDR;
				rd = sh[0];
				got_reg = got_reg && sh[0];
			end else if (!got_reg) begin
				ptr = sh;
				got_reg = 1'b1;
				o_pull = 1'b1;
			end else begin
				mem[ptr] = sh;
				ptr++;
				o_pull = 1'b1;
			end
			act = o_pull;
			first = 1'b0;
			bitc = 9;
		end else if (act && bitc == 8) begin
			o_pull = 1'b0;
			ptr++;
			bitc = 9;
		end else if (bitc == 9) begin
			bitc = 0;
			o_pull = act && rd && !mem[ptr][7];
		end else if (act && rd) begin
			o_pull = !mem[ptr][7 - bitc];
		end
	end
endmodule : scbr_i2c_dev

// [bench/tb_top.sv]
// Self-checking bench of the configuration store and bus relay
`timescale 1ns/100ps
module tb_top import scbr_pkg::*;;
	typedef struct packed {
		logic [7:0]  a;
		logic [15:0] d;
		logic [15:0] e;
	} scbr_row_s;
	typedef struct packed {
		logic [2:0] c;
		logic [7:0] r;
		logic [7:0] n;
		logic [3:0] s;
	} scbr_pt_s;
	localparam int GAP = 20;
	// Register writes and the value read back once settled
	localparam scbr_row_s ROWS [12] = '{
		'{8'h00, 16'h0064, 16'h0080}, '{8'h01, 16'h0005, 16'h0005},
		'{8'h02, 16'h1234, 16'h1234}, '{8'h03, 16'h0008, 16'h0008},
		'{8'h0B, 16'h0004, 16'h0008}, '{8'h07, 16'h0000, 16'h0008},
		'{8'h13, 16'h0FA0, 16'h0FA0}, '{8'h0F, 16'h0000, 16'h0FA0},
		'{8'h17, 16'h0000, 16'h0514}, '{8'h0C, 16'h03E8, 16'h0400},
		'{8'h10, 16'h9C40, 16'hFFFF}, '{8'h15, 16'h0007, 16'h0000}};
	// Relay commands: parameter, register, length, START count
	localparam scbr_pt_s PTS [6] = '{
		'{3'h2, 8'h10, 8'h04, 4'h1}, '{3'h1, 8'h10, 8'h04, 4'h2},
		'{3'h4, 8'h20, 8'h02, 4'h2}, '{3'h3, 8'h20, 8'h02, 4'h4},
		'{3'h6, 8'h20, 8'h02, 4'h2}, '{3'h5, 8'h20, 8'h02, 4'h4}};
	logic                     i_sys_clk = 1'b0;
	logic                     i_sys_rst = 1'b1;
	logic [7:0]               i_addr    = 8'h00;
	logic [15:0]              i_wdata   = 16'h0000;
	logic                     i_wr      = 1'b0;
	logic                     i_rd      = 1'b0;
	logic                     i_evt_en  = 1'b1;
	logic                     nack      = 1'b0;
	logic                     pull;
	logic                     sda;
	logic [15:0]              o_rdata;
	logic [15:0]              rd_v;
	logic                     o_pt_busy;
	scbr_evt_s                o_evt;
	scbr_i2c_s                o_i2c;
	logic [NUM_GRP-1:0][15:0] o_phys_range;
	logic [NUM_GRP-1:0][31:0] o_scale;
	int                       n_fail = 0;
	int                       total_checks = 0;
	int                       n_flush = 0;
	int                       n_batch = 0;
	int                       n_rate = 0;
	int                       n_range = 0;
	// Open-drain data line with pull-up; either end may pull it low
	assign sda = o_i2c.sda_oe_n & ~pull;
	// Clock
	always #5 i_sys_clk = ~i_sys_clk;
	// Event pulse counters
	always @(posedge i_sys_clk) begin
		n_flush <= n_flush + int'(o_evt.flush[0]);
		n_batch <= n_batch + int'(o_evt.batch_due[0]);
		n_rate  <= n_rate + int'(o_evt.rate_chg[1]);
		n_range <= n_range + int'(o_evt.range_chg[0]);
	end
	scbr_top #(.QTR_C(2), .GAP_C(GAP), .RATE_C(10), .MS_C(50)) dut (
		.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_rate_evt_en(i_evt_en), .i_range_evt_en(i_evt_en),
		.o_evt(o_evt), .o_phys_range(o_phys_range), .o_scale(o_scale),
		.o_pt_busy(o_pt_busy), .i_sda_in(sda), .o_i2c(o_i2c));
	scbr_i2c_dev slv (.i_scl(o_i2c.scl_oe_n), .i_sda(sda), .i_nack(nack),
		.o_pull(pull));
	// ----------
	// Shared tasks
	// ----------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_rd   <= 1'b0;
		#1 rd_v = o_rdata;
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : tick
	task automatic wait_idle(output int c);
		c = 0;
		while (o_pt_busy !== 1'b0 && c < 5000) begin
			@(posedge i_sys_clk);
			c++;
		end
		#1;
		chk(c < 5000, 1);
	endtask : wait_idle
	function automatic logic [15:0] pat(input logic [7:0] r, input int i);
		return {8'h00, r + 8'h40 + 8'(i)};
	endfunction : pat
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	// ----------
	// Main sequence
	// ----------
	initial begin
		int n0;
		int dur [6];
		tick(5);
		i_sys_rst <= 1'b0;
		chk({o_i2c, o_pt_busy, o_phys_range[2]}, 21'h0A0514);
		wr(8'h23, 16'h0055);
		rd(8'h23);
		chk(rd_v, 32'h0);
		foreach (ROWS[k]) begin
			wr(ROWS[k].a, ROWS[k].d);
			tick(12);
			rd(ROWS[k].a);
			chk(rd_v, ROWS[k].e);
		end
		chk(o_scale[1], 32'h00001F40);
		// Rate change lands only after the settling delay
		n0 = n_rate;
		wr(8'h04, 16'h0032);
		rd(8'h04);
		chk(rd_v, 32'h0);
		tick(12);
		rd(8'h04);
		chk(rd_v, 32'h40);
		chk(n_rate - n0, 1);
		// Latency timer fires, zero latency flushes and stops it
		wr(8'h01, 16'h0001);
		n0 = n_batch;
		tick(110);
		chk((n_batch - n0) inside {[2:3]}, 1);
		n0 = n_flush;
		wr(8'h01, 16'h0000);
		tick(3);
		chk(n_flush - n0, 1);
		n0 = n_batch;
		tick(110);
		chk(n_batch - n0, 0);
		// Larger shared range signals the host and rescales
		n0 = n_range;
		wr(8'h0B, 16'h0010);
		tick(4);
		chk(n_range - n0, 1);
		chk(o_scale[0], 32'h00000020);
		// Every relay command, with a refused write while busy
		foreach (PTS[k]) begin
			n0 = slv.n_start;
			wr(8'h20, 16'h002A);
			wr(8'h21, {8'h00, PTS[k].r});
			wr(8'h22, {8'h00, PTS[k].n});
			for (int i = 0; i < 4; i++) begin
				wr(8'h24 + 8'(i), PTS[k].c[0] ? 16'h0000 : pat(PTS[k].r, i));
			end
			wr(PT_CMD, {13'h0000, PTS[k].c});
			tick(1);
			wr(8'h20, 16'h007F);
			rd(8'h23);
			chk(rd_v, 32'h0);
			wait_idle(dur[k]);
			rd(8'h23);
			chk(rd_v, 32'h1);
			rd(8'h20);
			chk(rd_v, 32'h2A);
			chk(slv.n_start - n0, PTS[k].s);
			for (int i = 0; i < PTS[k].n; i++) begin
				rd(8'h24 + 8'(i));
				chk(PTS[k].c[0] ? rd_v : {8'h00, slv.mem[PTS[k].r + 8'(i)]},
					pat(PTS[k].r, i));
			end
		end
		chk((dur[4] - dur[2]) inside {[GAP:GAP + 4]}, 1);
		chk((dur[5] - dur[3]) inside {[GAP:GAP + 4]}, 1);
		// Over-long request fails at once without bus activity
		wr(8'h22, 16'h0005);
		wr(PT_CMD, 16'h0002);
		tick(1);
		chk({o_pt_busy, o_i2c}, 5'h05);
		rd(8'h23);
		chk(rd_v, 32'h2);
		// Target refuses its address
		nack <= 1'b1;
		wr(8'h22, 16'h0001);
		wr(PT_CMD, 16'h0001);
		tick(3);
		chk(o_pt_busy, 1'b1);
		wait_idle(n0);
		rd(8'h23);
		chk(rd_v, 32'h2);
		stop_test();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
endmodule : tb_top
